// *** common/pfm_pkg.sv ***
// register map, reset values and field layout of the pin function mux
package pfm_pkg;
   // register indices on the plain register port
   localparam logic [3:0] ADR_DRIVE = 4'h0;
   localparam logic [3:0] ADR_PA_SEL_LO = 4'h1;
   localparam logic [3:0] ADR_PA_SEL_HI = 4'h2;
   localparam logic [3:0] ADR_PB_SEL_LO = 4'h3;
   localparam logic [3:0] ADR_PB_SEL_HI = 4'h4;
   localparam logic [3:0] ADR_IN_SRC_LO = 4'h5;
   localparam logic [3:0] ADR_IN_SRC_HI = 4'h6;
   localparam logic [3:0] ADR_PA_DIR = 4'h7;
   localparam logic [3:0] ADR_PB_DIR = 4'h8;
   localparam logic [3:0] ADR_PA_DATA = 4'h9;
   localparam logic [3:0] ADR_PB_DATA = 4'hA;
   // implemented-bit masks, unimplemented bits read zero
   localparam logic [7:0] MASK_PA_SEL_LO = 8'hCF;
   localparam logic [7:0] MASK_PB_SEL_HI = 8'h0F;
   localparam logic [7:0] MASK_IN_SRC_HI = 8'h1F;
   localparam logic [7:0] MASK_PB = 8'h3F;
   // reset values
   localparam logic [7:0] RST_SEL = 8'h00;
   localparam logic [7:0] RST_DRIVE = 8'h00;
   localparam logic [7:0] RST_DIR = 8'hFF;
   localparam logic [7:0] RST_DATA = 8'hFF;
   // drive-strength field positions
   localparam int DRV_PB54_LSB = 6;
   localparam int DRV_PB30_LSB = 4;
   localparam int DRV_PA74_LSB = 2;
   localparam int DRV_PA30_LSB = 0;
   // analog candidate masks (one bit per selection code)
   localparam logic [3:0] ANA_NONE = 4'h0;
   localparam logic [3:0] ANA_CODE2 = 4'h4;
   localparam logic [3:0] ANA_CODE3 = 4'h8;
   // function codes that matter outside the decoder
   localparam logic [1:0] CODE_1 = 2'h1;
   localparam logic [1:0] CODE_2 = 2'h2;
   localparam logic [1:0] CODE_3 = 2'h3;
endpackage

// *** dv/pfm_periph_model.sv ***
// peripheral and pad model facing the pin mux
`timescale 1ns/1ps
`default_nettype none
module pfm_periph_model (
   input wire logic perEn,
   input wire logic [10:0] perVal,
   input wire logic [7:0] extA,
   input wire logic [5:0] extB,
   input wire logic [7:0] paOut,
   input wire logic [7:0] paOe,
   input wire logic [5:0] pbOut,
   input wire logic [5:0] pbOe,
   output logic [7:0] paIn,
   output logic [5:0] pbIn,
   output logic [10:0] perOut
);
   // pad level: own drive wins, else outside level
   assign paIn = (paOe & paOut) | (~paOe & extA);
   assign pbIn = (pbOe & pbOut) | (~pbOe & extB);
   // peripherals stay quiet while disabled
   assign perOut = perEn ? perVal : 11'h000;
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the pin function mux
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct {int kind; logic [15:0] exp; logic [15:0] msk;} pfm_note_t;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdata, paIn, paOut, paOe;
   logic [5:0] pbIn, pbOut, pbOe;
   logic [15:0] paDrive;
   logic [11:0] pbDrive;
   logic [10:0] perOut;
   logic [10:0] pv = 11'h000; // peripheral values when enabled
   logic perEn = 1'b0;
   logic [7:0] extA = 8'h00; // outside pad levels
   logic [5:0] extB = 6'h00;
   logic uartRx, sckIn, sdaIn, scsIn, intIn, ptckIn, ptpiIn, ctckIn, vrefEn, vrefiEn;
   logic [3:0] anEn;
   logic snap = 1'b0; // asks the monitor to compare pin outputs
   logic pendRd = 1'b0;
   int miscompares = 0;
   int check_count = 0;
   pfm_note_t notes[$];
   string nm [10] = '{"regRdata", "paOut", "paOe", "paDrive", "pbDrive", "anEn", "vref", "periphIn",
      "pbPins", "routedIn"};

   // 40 MHz clock
   initial begin
      forever #12.5 clk = ~clk;
   end

   pfm_pin_mux #(.ADDR_W(4)) dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .paIn(paIn), .paOut(paOut), .paOe(paOe),
      .pbIn(pbIn), .pbOut(pbOut), .pbOe(pbOe), .paDrive(paDrive), .pbDrive(pbDrive),
      .ctpOut(perOut[0]), .ptpOut(perOut[1]), .uartTx(perOut[2]), .uartTxOe(perOut[3]),
      .sckOut(perOut[4]), .sckOe(perOut[5]), .sdoOut(perOut[6]), .sdaOut(perOut[7]),
      .sdaOe(perOut[8]), .scsOut(perOut[9]), .scsOe(perOut[10]), .uartRx(uartRx), .sckIn(sckIn),
      .sdaIn(sdaIn), .scsIn(scsIn), .intIn(intIn), .ptckIn(ptckIn), .ptpiIn(ptpiIn), .ctckIn(ctckIn),
      .anEn(anEn), .vrefEn(vrefEn), .vrefiEn(vrefiEn));

   pfm_periph_model model (.perEn(perEn), .perVal(pv), .extA(extA), .extB(extB), .paOut(paOut),
      .paOe(paOe), .pbOut(pbOut), .pbOe(pbOe), .paIn(paIn), .pbIn(pbIn), .perOut(perOut));

   // verdict and end of run
   task automatic complete_run();
      if (miscompares == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // one-cycle register write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   // one-cycle register read, expected data noted first
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      notes.push_back('{0, {8'h00, e}, 16'h00FF});
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
   endtask

   task automatic note(input int k, input logic [15:0] e, input logic [15:0] m);
      notes.push_back('{k, e, m});
   endtask

   // one-cycle compare request for the pin outputs
   task automatic shot();
      @(posedge clk);
      snap <= 1'b1;
      @(posedge clk);
      snap <= 1'b0;
   endtask

   // observed value for each kind of note
   function automatic logic [15:0] seen(input int k);
      case (k)
         0: seen = {8'h00, regRdata};
         1: seen = {8'h00, paOut};
         2: seen = {8'h00, paOe};
         3: seen = paDrive;
         4: seen = {4'h0, pbDrive};
         5: seen = {12'h000, anEn};
         6: seen = {14'h0000, vrefEn, vrefiEn};
         7: seen = {12'h000, uartRx, sckIn, sdaIn, intIn};
         8: seen = {4'h0, pbOe, pbOut};
         default: seen = {12'h000, scsIn, ptckIn, ptpiIn, ctckIn};
      endcase
   endfunction

   // expected {enable, out} of one port A pin
   function automatic logic [1:0] pinExp(input int p, input logic [1:0] c, input logic dr, input logic dt);
      logic [1:0] g;
      g = {~dr, dt};
      case (p)
         0: pinExp = c == 1 ? {1'b1, pv[1]} : c == 2 ? 2'b00 : g;
         1: pinExp = c == 1 ? {1'b1, pv[0]} : c == 2 ? pv[5:4] : c == 3 ? 2'b00 : g;
         3: pinExp = c == 1 ? {1'b1, pv[0]} : c == 2 ? pv[3:2] : c == 3 ? pv[10:9] : g;
         4: pinExp = c == 1 ? {1'b1, pv[6]} : c == 2 ? 2'b00 : g;
         5: pinExp = c == 1 ? {1'b1, pv[2]} : c == 2 ? pv[8:7] : c == 3 ? 2'b00 : g;
         6: pinExp = c == 1 ? {1'b1, pv[2]} : c == 2 ? pv[10:9] : c == 3 ? 2'b00 : g;
         7: pinExp = c == 1 ? pv[3:2] : c == 2 ? {1'b1, pv[6]} : c == 3 ? 2'b00 : g;
         default: pinExp = g;
      endcase
   endfunction

   // takes the oldest note and compares it
   task automatic take();
      pfm_note_t n;
      logic [15:0] a;
      check_count++;
      if (notes.size() == 0) begin
         miscompares++;
         $display("wrong value note queue expected entry seen none");
         return;
      end
      n = notes.pop_front();
      a = seen(n.kind);
      if ((a & n.msk) !== (n.exp & n.msk)) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm[n.kind], n.exp & n.msk, a & n.msk);
      end
   endtask

   // monitor: read data one cycle after the strobe, pins on request
   always @(negedge clk) begin
      if (pendRd) begin
         take();
      end
      while (snap && notes.size() > 0) begin
         take();
      end
      pendRd = regRd;
   end

   // hang guard
   initial begin
      #500000;
      miscompares++;
      $display("wrong value run time expected end seen hang");
      complete_run();
   end

   // main sequence
   initial begin
      logic [7:0] w, m, d, dir, dat, lvl, eo, ee;
      logic [1:0] c [8];
      logic [1:0] po;
      logic ux;
      logic [15:0] e;
      logic [5:0] bd, bt, lb; // port B direction, data and pad level
      logic [7:0] sl, sh; // input source selections
      w = 8'($urandom(32'h4C0E));
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      // reset values, unmapped index
      for (int i = 0; i < 7; i++) rd(4'(i), 8'h00);
      rd(pfm_pkg::ADR_PA_DIR, 8'hFF);
      wr(4'hB, w);
      rd(4'hB, 8'h00);
      // write and read back, unimplemented bits read zero
      for (int i = 0; i < 9; i++) begin
         w = 8'($urandom());
         m = i == 1 ? pfm_pkg::MASK_PA_SEL_LO : i == 4 ? pfm_pkg::MASK_PB_SEL_HI :
             i == 6 ? pfm_pkg::MASK_IN_SRC_HI : i == 8 ? pfm_pkg::MASK_PB : 8'hFF;
         wr(4'(i), w);
         rd(4'(i), w & m);
      end
      wr(pfm_pkg::ADR_IN_SRC_LO, 8'h00);
      wr(pfm_pkg::ADR_IN_SRC_HI, 8'h00);
      // every strength code in every drive field
      for (int k = 0; k < 4; k++) begin
         d = {2'(k), 2'(3 - k), 2'(k ^ 1), 2'(k ^ 2)};
         wr(pfm_pkg::ADR_DRIVE, d);
         repeat (2) @(posedge clk);
         for (int p = 0; p < 8; p++) e[2*p +: 2] = p > 3 ? d[3:2] : d[1:0];
         note(3, e, 16'hFFFF);
         note(4, {4'h0, d[7:6], d[7:6], {4{d[5:4]}}}, 16'h0FFF);
         shot();
      end
      // function selection: every code on every pin, then random ones
      for (int k = 0; k < 12; k++) begin
         perEn <= 1'b0;
         dir = 8'($urandom());
         dat = 8'($urandom());
         bd = 6'($urandom());
         bt = 6'($urandom());
         sl = 8'($urandom());
         sh = 8'($urandom());
         for (int p = 0; p < 8; p++) c[p] = k < 4 ? 2'(k + p) : 2'($urandom());
         // odd passes: pins whose code shares a digital input are made inputs
         for (int p = 0; p < 8; p++) begin
            if (k % 2 == 1 && (c[p] == 0 || (c[p] == 3 && (p == 0 || p == 4)))) dir[p] = 1'b1;
         end
         wr(pfm_pkg::ADR_PA_DIR, dir);
         wr(pfm_pkg::ADR_PA_DATA, dat);
         wr(pfm_pkg::ADR_PA_SEL_LO, {c[3], 2'b00, c[1], c[0]});
         wr(pfm_pkg::ADR_PA_SEL_HI, {c[7], c[6], c[5], c[4]});
         wr(pfm_pkg::ADR_PB_DIR, {2'h0, bd});
         wr(pfm_pkg::ADR_PB_DATA, {2'h0, bt});
         wr(pfm_pkg::ADR_IN_SRC_LO, sl);
         wr(pfm_pkg::ADR_IN_SRC_HI, sh);
         pv <= 11'($urandom());
         extA <= 8'($urandom());
         extB <= 6'($urandom());
         @(posedge clk);
         perEn <= 1'b1;
         repeat (4) @(posedge clk);
         for (int p = 0; p < 8; p++) begin
            po = pinExp(p, c[p], dir[p], dat[p]);
            ee[p] = po[1];
            eo[p] = po[0];
            lvl[p] = po[1] ? po[0] : extA[p];
         end
         lb = (~bd & bt) | (bd & extB);
         ux = c[3] == 2 ? lvl[3] : c[7] == 1 ? lvl[7] : 1'b1;
         note(1, {8'h00, eo}, {8'h00, ee});
         note(2, {8'h00, ee}, 16'h00FF);
         note(5, {12'h000, c[4] == 2, c[5] == 3, c[1] == 3, c[0] == 2}, 16'h000F);
         note(6, {14'h0000, c[7] == 3, c[6] == 3}, 16'h0003);
         note(7, {12'h000, ux, c[1] == 2 ? lvl[1] : 1'b1, c[5] == 2 ? lvl[5] : 1'b1, sh[0] ? lb[5] : lvl[0]},
              {12'h000, 3'b111, c[0] == 0 || c[0] == 3});
         note(8, {4'h0, ~bd, bt}, 16'h0FFF);
         note(9, {12'h000, sl[3:2] == 1 ? lvl[3] : sl[3:2] == 2 ? lb[5] : lvl[6], sh[1] ? lb[4] : lvl[7],
              sh[2] ? lb[0] : lvl[6], sh[4:3] == 1 ? lb[1] : sh[4:3] == 2 ? lvl[4] : lvl[5]}, 16'h000F);
         shot();
      end
      repeat (3) @(posedge clk);
      if (notes.size() != 0) begin
         miscompares++;
         $display("wrong value notes left expected 0 seen %0d", notes.size());
      end
      complete_run();
   end
endmodule
`default_nettype wire

// *** hw/pfm_pin_mux.sv ***
// pin function mux, drive strength and port direction registers
//
// How it works
// (RULE_01) top drive field sets port B pins 5,4
// (RULE_02) drive bits 5:4 set port B 3..0
// (RULE_03) drive bits 3:2 set port A 7..4
// (RULE_04) drive bits 1:0 set port A 3..0
// (RULE_05) select pin, configure, then enable peripheral
// (RULE_06) shared digital inputs need direction set input
// (RULE_07) disable peripheral before changing pin select
// (RULE_08) port A pin 3 from low select 7:6
// (RULE_09) low select bits 5:4 read zero
// (RULE_10) port A pin 1 from low select 3:2
// (RULE_11) port A pin 0 from low select 1:0
// (RULE_12) port A pin 7 from high select 7:6
// (RULE_13) port A pin 6 from high select 5:4
// (RULE_14) port A pin 5 from high select 3:2
// (RULE_15) port A pin 4 from high select 1:0
// (RULE_16) direction one is input, zero drives output
// (RULE_17) reset clears all select fields to GPIO
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pfm_pin_mux #(
   parameter int ADDR_W = 4
) (
   input wire logic clk,
   input wire logic reset_n,
   // register port
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // package pins
   input wire logic [7:0] paIn,
   output logic [7:0] paOut,
   output logic [7:0] paOe,
   input wire logic [5:0] pbIn,
   output logic [5:0] pbOut,
   output logic [5:0] pbOe,
   output logic [15:0] paDrive,
   output logic [11:0] pbDrive,
   // peripheral outputs toward pins
   input wire logic ctpOut,
   input wire logic ptpOut,
   input wire logic uartTx,
   input wire logic uartTxOe,
   input wire logic sckOut,
   input wire logic sckOe,
   input wire logic sdoOut,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic scsOut,
   input wire logic scsOe,
   // peripheral inputs from pins
   output logic uartRx,
   output logic sckIn,
   output logic sdaIn,
   output logic scsIn,
   output logic intIn,
   output logic ptckIn,
   output logic ptpiIn,
   output logic ctckIn,
   // analog claims: AN4, AN3, AN1, AN0
   output logic [3:0] anEn,
   output logic vrefEn,
   output logic vrefiEn
);
   // address must reach every register index
   if (ADDR_W < 4) begin : gBadAddr
      $error("ADDR_W too small for the register map");
   end

   // software-visible registers
   logic [7:0] drvQ;
   logic [7:0] paSelLoQ;
   logic [7:0] paSelHiQ;
   logic [7:0] pbSelLoQ;
   logic [7:0] pbSelHiQ;
   logic [7:0] srcLoQ;
   logic [7:0] srcHiQ;
   logic [7:0] paDirQ;
   logic [5:0] pbDirQ;
   logic [7:0] paDataQ;
   logic [5:0] pbDataQ;
   // output flops
   logic [7:0] rdataQ;
   logic [7:0] paOutQ;
   logic [7:0] paOeQ;
   logic [5:0] pbOutQ;
   logic [5:0] pbOeQ;
   logic [15:0] paDrvQ;
   logic [11:0] pbDrvQ;
   logic [7:0] perInQ;
   logic [5:0] anaQ;

   // write decode, one strobe per register
   wire logic [3:0] adr = regAddr[3:0];
   wire logic hiZero = (ADDR_W == 4) ? 1'b1 : (regAddr >> 4) == '0;
   wire logic wrDrv = regWr && hiZero && adr == pfm_pkg::ADR_DRIVE;
   wire logic wrPaLo = regWr && hiZero && adr == pfm_pkg::ADR_PA_SEL_LO;
   wire logic wrPaHi = regWr && hiZero && adr == pfm_pkg::ADR_PA_SEL_HI;
   wire logic wrPbLo = regWr && hiZero && adr == pfm_pkg::ADR_PB_SEL_LO;
   wire logic wrPbHi = regWr && hiZero && adr == pfm_pkg::ADR_PB_SEL_HI;
   wire logic wrSrcLo = regWr && hiZero && adr == pfm_pkg::ADR_IN_SRC_LO;
   wire logic wrSrcHi = regWr && hiZero && adr == pfm_pkg::ADR_IN_SRC_HI;
   wire logic wrPaDir = regWr && hiZero && adr == pfm_pkg::ADR_PA_DIR;
   wire logic wrPbDir = regWr && hiZero && adr == pfm_pkg::ADR_PB_DIR;
   wire logic wrPaDat = regWr && hiZero && adr == pfm_pkg::ADR_PA_DATA;
   wire logic wrPbDat = regWr && hiZero && adr == pfm_pkg::ADR_PB_DATA;

   // data reads show pin level for inputs, latch for outputs
   wire logic [7:0] paView = (paIn & paDirQ) | (paDataQ & ~paDirQ);
   wire logic [5:0] pbView = (pbIn & pbDirQ) | (pbDataQ & ~pbDirQ);

   // read mux, unmapped addresses answer zero
   logic [7:0] rdataD;
   always_comb begin
      rdataD = 8'h00;
      if (hiZero) begin
         unique case (adr)
            pfm_pkg::ADR_DRIVE: rdataD = drvQ;
            pfm_pkg::ADR_PA_SEL_LO: rdataD = paSelLoQ;
            pfm_pkg::ADR_PA_SEL_HI: rdataD = paSelHiQ;
            pfm_pkg::ADR_PB_SEL_LO: rdataD = pbSelLoQ;
            pfm_pkg::ADR_PB_SEL_HI: rdataD = pbSelHiQ;
            pfm_pkg::ADR_IN_SRC_LO: rdataD = srcLoQ;
            pfm_pkg::ADR_IN_SRC_HI: rdataD = srcHiQ;
            pfm_pkg::ADR_PA_DIR: rdataD = paDirQ;
            pfm_pkg::ADR_PB_DIR: rdataD = {2'h0, pbDirQ};
            pfm_pkg::ADR_PA_DATA: rdataD = paView;
            pfm_pkg::ADR_PB_DATA: rdataD = {2'h0, pbView};
            default: rdataD = 8'h00;
         endcase
      end
   end

   // selection and drive registers, cleared to GPIO on reset
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         drvQ <= pfm_pkg::RST_DRIVE;
         paSelLoQ <= pfm_pkg::RST_SEL; // see RULE_17
         paSelHiQ <= pfm_pkg::RST_SEL; // see RULE_17
         pbSelLoQ <= pfm_pkg::RST_SEL; // see RULE_17
         pbSelHiQ <= pfm_pkg::RST_SEL; // see RULE_17
         srcLoQ <= pfm_pkg::RST_SEL;
         srcHiQ <= pfm_pkg::RST_SEL;
      end else begin
         if (wrDrv) drvQ <= regWdata;
         // unimplemented bits are never stored
         if (wrPaLo) paSelLoQ <= regWdata & pfm_pkg::MASK_PA_SEL_LO; // see RULE_09
         if (wrPaHi) paSelHiQ <= regWdata;
         if (wrPbLo) pbSelLoQ <= regWdata;
         if (wrPbHi) pbSelHiQ <= regWdata & pfm_pkg::MASK_PB_SEL_HI;
         if (wrSrcLo) srcLoQ <= regWdata;
         if (wrSrcHi) srcHiQ <= regWdata & pfm_pkg::MASK_IN_SRC_HI;
      end
   end

   // direction and data latches, all pins input after reset
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         paDirQ <= pfm_pkg::RST_DIR;
         pbDirQ <= pfm_pkg::RST_DIR[5:0];
         paDataQ <= pfm_pkg::RST_DATA;
         pbDataQ <= pfm_pkg::RST_DATA[5:0];
      end else begin
         if (wrPaDir) paDirQ <= regWdata;
         if (wrPbDir) pbDirQ <= regWdata[5:0];
         if (wrPaDat) paDataQ <= regWdata;
         if (wrPbDat) pbDataQ <= regWdata[5:0];
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdataQ <= 8'h00;
      end else begin
         rdataQ <= regRd ? rdataD : 8'h00;
      end
   end

   // per-pin selection codes of port A
   wire logic [1:0] codeA [8];
   assign codeA[0] = paSelLoQ[1:0]; // see RULE_11
   assign codeA[1] = paSelLoQ[3:2]; // see RULE_10
   assign codeA[2] = 2'h0;
   assign codeA[3] = paSelLoQ[7:6]; // see RULE_08
   assign codeA[4] = paSelHiQ[1:0]; // see RULE_15
   assign codeA[5] = paSelHiQ[3:2]; // see RULE_14
   assign codeA[6] = paSelHiQ[5:4]; // see RULE_13
   assign codeA[7] = paSelHiQ[7:6]; // see RULE_12

   // gpio candidate: latch out, enable while direction is output
   wire logic [7:0] g = paDataQ;
   wire logic [7:0] ge = ~paDirQ; // see RULE_16

   // candidates ordered code 3, 2, 1, 0
   wire logic [3:0] cO [8];
   wire logic [3:0] cE [8];
   wire logic [3:0] cA [8];
   // pin 0: gpio/int, periodic timer out, AN0, gpio/int
   assign cO[0] = {g[0], 1'b0, ptpOut, g[0]}; // see RULE_11
   assign cE[0] = {ge[0], 1'b0, 1'b1, ge[0]};
   assign cA[0] = pfm_pkg::ANA_CODE2;
   // pin 1: gpio, compact timer out, serial clock, AN1
   assign cO[1] = {1'b0, sckOut, ctpOut, g[1]}; // see RULE_10
   assign cE[1] = {1'b0, sckOe, 1'b1, ge[1]};
   assign cA[1] = pfm_pkg::ANA_CODE3;
   // pin 2: gpio only
   assign cO[2] = {4{g[2]}};
   assign cE[2] = {4{ge[2]}};
   assign cA[2] = pfm_pkg::ANA_NONE;
   // pin 3: gpio, compact timer out, shared uart line, chip select
   assign cO[3] = {scsOut, uartTx, ctpOut, g[3]}; // see RULE_08
   assign cE[3] = {scsOe, uartTxOe, 1'b1, ge[3]};
   assign cA[3] = pfm_pkg::ANA_NONE;
   // pin 4: gpio/clock in, serial data out, AN4, gpio/clock in
   assign cO[4] = {g[4], 1'b0, sdoOut, g[4]}; // see RULE_15
   assign cE[4] = {ge[4], 1'b0, 1'b1, ge[4]};
   assign cA[4] = pfm_pkg::ANA_CODE2;
   // pin 5: gpio/clock in, uart transmit, serial data, AN3
   assign cO[5] = {1'b0, sdaOut, uartTx, g[5]}; // see RULE_14
   assign cE[5] = {1'b0, sdaOe, 1'b1, ge[5]};
   assign cA[5] = pfm_pkg::ANA_CODE3;
   // pin 6: gpio/capture in, uart transmit, chip select, ref input
   assign cO[6] = {1'b0, scsOut, uartTx, g[6]}; // see RULE_13
   assign cE[6] = {1'b0, scsOe, 1'b1, ge[6]};
   assign cA[6] = pfm_pkg::ANA_CODE3;
   // pin 7: gpio/clock in, shared uart line, serial out, reference
   assign cO[7] = {1'b0, sdoOut, uartTx, g[7]}; // see RULE_12
   assign cE[7] = {1'b0, 1'b1, uartTxOe, ge[7]};
   assign cA[7] = pfm_pkg::ANA_CODE3;

   // per-pin decode and drive strength
   wire logic [7:0] pinO;
   wire logic [7:0] pinE;
   wire logic [7:0] pinA;
   wire logic [15:0] paDrvD;
   for (genvar i = 0; i < 8; i++) begin : gPin
      pfm_sel_dec uDec (
         .code(codeA[i]),
         .candOut(cO[i]),
         .candOe(cE[i]),
         .candAna(cA[i]),
         .pinOut(pinO[i]),
         .pinOe(pinE[i]),
         .pinAna(pinA[i])
      );
      if (i < 4) begin : gLow
         assign paDrvD[2*i+:2] = drvQ[pfm_pkg::DRV_PA30_LSB+:2]; // see RULE_04
      end else begin : gHigh
         assign paDrvD[2*i+:2] = drvQ[pfm_pkg::DRV_PA74_LSB+:2]; // see RULE_03
      end
   end

   // port B drive strength: pins 5,4 and pins 3..0
   wire logic [11:0] pbDrvD = {{2{drvQ[pfm_pkg::DRV_PB54_LSB+:2]}}, // see RULE_01
                              {4{drvQ[pfm_pkg::DRV_PB30_LSB+:2]}}}; // see RULE_02

   // peripheral input routing from pins
   wire logic rxD = (codeA[3] == pfm_pkg::CODE_2) ? paIn[3] :
                    (codeA[7] == pfm_pkg::CODE_1) ? paIn[7] : 1'b1;
   wire logic sckD = (codeA[1] == pfm_pkg::CODE_2) ? paIn[1] : 1'b1;
   wire logic sdaD = (codeA[5] == pfm_pkg::CODE_2) ? paIn[5] : 1'b1;
   wire logic scsD = (srcLoQ[3:2] == pfm_pkg::CODE_1) ? paIn[3] :
                     (srcLoQ[3:2] == pfm_pkg::CODE_2) ? pbIn[5] : paIn[6];
   wire logic intD = srcHiQ[0] ? pbIn[5] : paIn[0];
   wire logic ptckD = srcHiQ[1] ? pbIn[4] : paIn[7];
   wire logic ptpiD = srcHiQ[2] ? pbIn[0] : paIn[6];
   wire logic ctckD = (srcHiQ[4:3] == pfm_pkg::CODE_1) ? pbIn[1] :
                      (srcHiQ[4:3] == pfm_pkg::CODE_2) ? paIn[4] : paIn[5];

   // pad-facing output flops
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         paOutQ <= 8'h00;
         paOeQ <= 8'h00;
         pbOutQ <= 6'h00;
         pbOeQ <= 6'h00;
         paDrvQ <= 16'h0000;
         pbDrvQ <= 12'h000;
      end else begin
         paOutQ <= pinO;
         paOeQ <= pinE;
         pbOutQ <= pbDataQ; // port B stays general purpose
         pbOeQ <= ~pbDirQ; // see RULE_16
         paDrvQ <= paDrvD;
         pbDrvQ <= pbDrvD;
      end
   end

   // peripheral-facing flops, idle inputs high
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         perInQ <= 8'hFF;
         anaQ <= 6'h00;
      end else begin
         perInQ <= {ctckD, ptpiD, ptckD, intD, scsD, sdaD, sckD, rxD};
         anaQ <= {pinA[7], pinA[6], pinA[4], pinA[5], pinA[1], pinA[0]};
      end
   end

   // ports straight from flops
   assign regRdata = rdataQ;
   assign paOut = paOutQ;
   assign paOe = paOeQ;
   assign pbOut = pbOutQ;
   assign pbOe = pbOeQ;
   assign paDrive = paDrvQ;
   assign pbDrive = pbDrvQ;
   assign {ctckIn, ptpiIn, ptckIn, intIn, scsIn, sdaIn, sckIn, uartRx} = perInQ;
   assign anEn = anaQ[3:0];
   assign vrefiEn = anaQ[4];
   assign vrefEn = anaQ[5];

   // drive code written reaches port A and port B pins two edges later
   AST_DRV_PB54: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_01
      wrDrv ##2 1'b1 |-> pbDrive[11:10] == $past(regWdata[7:6], 2) && pbDrive[9:8] == pbDrive[11:10])
      else $error("port B pins 5,4 drive not from top field");
   AST_DRV_PB30: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_02
      wrDrv ##2 1'b1 |-> pbDrive[7:0] == {4{$past(regWdata[5:4], 2)}})
      else $error("port B pins 3..0 drive wrong");
   AST_DRV_PA: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_03
      wrDrv ##2 1'b1 |-> paDrive[15:8] == {4{$past(regWdata[3:2], 2)}})
      else $error("port A pins 7..4 drive wrong");
   AST_DRV_PA30: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_04
      wrDrv ##2 1'b1 |-> paDrive[7:0] == {4{$past(regWdata[1:0], 2)}})
      else $error("port A pins 3..0 drive wrong");
   // compact timer owns pin 3 one edge after its code settles
   AST_PA3_CTP: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_08
      paSelLoQ[7:6] == pfm_pkg::CODE_1 |=> paOe[3] && paOut[3] == $past(ctpOut))
      else $error("pin 3 not driven by compact timer");
   AST_SEL_LO_RD: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_09
      regRd && adr == pfm_pkg::ADR_PA_SEL_LO && hiZero |=> regRdata[5:4] == 2'h0)
      else $error("low select bits 5:4 not zero");
   AST_PA1_AN1: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_10
      paSelLoQ[3:2] == pfm_pkg::CODE_3 |=> anEn[1] && !paOe[1])
      else $error("pin 1 analog claim missing");
   AST_PA0_GPIO: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_11
      (paSelLoQ[1:0] == 2'h0 || paSelLoQ[1:0] == pfm_pkg::CODE_3) |=>
         paOe[0] == !$past(paDirQ[0]) && paOut[0] == $past(paDataQ[0]) && !anEn[0])
      else $error("pin 0 general purpose path wrong");
   AST_PA7_VREF: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_12
      paSelHiQ[7:6] == pfm_pkg::CODE_3 |=> vrefEn && !paOe[7])
      else $error("pin 7 reference claim missing");
   AST_PA6_TX: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_13
      paSelHiQ[5:4] == pfm_pkg::CODE_1 |=> paOe[6] && paOut[6] == $past(uartTx))
      else $error("pin 6 not uart transmit");
   AST_PA5_SDA: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_14
      paSelHiQ[3:2] == pfm_pkg::CODE_2 |=> paOe[5] == $past(sdaOe) && sdaIn == $past(paIn[5]))
      else $error("pin 5 serial data path wrong");
   AST_PA4_AN4: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_15
      paSelHiQ[1:0] == pfm_pkg::CODE_2 |=> anEn[3] && !paOe[4])
      else $error("pin 4 analog claim missing");
   AST_PB_DIR: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_16
      wrPbDir |-> ##2 pbOe == ~$past(regWdata[5:0], 2))
      else $error("port B enable not inverse of direction");
   AST_RST_SEL: assert property (@(posedge clk) // see RULE_17
      !reset_n |=> paSelLoQ == 8'h00 && paSelHiQ == 8'h00 && pbSelLoQ == 8'h00 && pbSelHiQ == 8'h00)
      else $error("select fields not cleared by reset");
endmodule
`default_nettype wire

// *** hw/pfm_sel_dec.sv ***
// one pin: picks output, enable and analog claim by a 2-bit code
`timescale 1ns/1ps
`default_nettype none
module pfm_sel_dec (
   input wire logic [1:0] code,
   input wire logic [3:0] candOut,
   input wire logic [3:0] candOe,
   input wire logic [3:0] candAna,
   output logic pinOut,
   output logic pinOe,
   output logic pinAna
);
   // index the candidate vectors by the selection code
   assign pinOut = candOut[code];
   assign pinOe = candOe[code];
   assign pinAna = candAna[code];
endmodule
`default_nettype wire
